// [src/fpic_top.sv]
// Fixed priority interrupt controller: flags, masks, arbitration, core hand-off
//
// Contract
// - NMI ignores enable and masks, ranks first
// - NMI or any unmasked request drives standby release output
// - Fourteen maskable sources plus one NMI
// - Watchdog-mode overflow raises NMI, vector 0004H
// - Interval-mode overflow raises maskable level 0
// - Lowest level number wins among pending
// - Pin edges levels 1-4, vectors 0006H-000CH
// - Serial A receive ends share level 5
// - Serial B level 6, serial A transmit 7
// - Interval tick level 8, wide timer 9
// - Byte timer level 10, event counter 11
// - Watch tick level 12, key return 13
// - Flag set by source or software write
// - Request flags reset to zero
// - Acknowledge clears its request flag
// - Mask 0 permits, mask 1 blocks
// - Mask flags reset to all ones
// - Watchdog request flag usable in interval mode only
// - Watchdog mask read undefined in watchdog mode
// - Port pin output toggles set pin flags
// - Service needs flag, clear mask, global enable
// - Service starts 9 to 19 clocks after request
`timescale 1ns/1ps
module fpic_top (
  input  wire logic        i_core_clk,                // CPU clock, 100 MHz
  input  wire logic        i_rst,                     // Async reset, active high
  input  wire logic        i_wdt_overflow,            // Watchdog overflow pulse
  input  wire logic        i_wdt_interval_mode,       // 1: watchdog used as interval timer
  input  wire logic        i_pin_edge_irq_0,          // Pin 0 valid edge pulse
  input  wire logic        i_pin_edge_irq_1,          // Pin 1 valid edge pulse
  input  wire logic        i_pin_edge_irq_2,          // Pin 2 valid edge pulse
  input  wire logic        i_pin_edge_irq_3,          // Pin 3 valid edge pulse
  input  wire logic        i_serial_a_async_rx_done,  // Serial A async receive end
  input  wire logic        i_serial_a_sync_rx_done,   // Serial A 3-wire receive end
  input  wire logic        i_serial_b_sync_done,      // Serial B 3-wire transfer end
  input  wire logic        i_serial_a_async_tx_done,  // Serial A async transmit end
  input  wire logic        i_interval_tick_irq,       // Interval timer event
  input  wire logic        i_wide_timer_match_irq,    // 16-bit timer match
  input  wire logic        i_byte_timer_match_irq,    // 8-bit timer match
  input  wire logic        i_event_counter_match_irq, // Event counter match
  input  wire logic        i_watch_tick_irq,          // Watch timer event
  input  wire logic        i_key_return_irq,          // Key return detect pulse
  input  wire logic [1:0]  i_reg_sel,                 // Flag register select
  input  wire logic        i_reg_wr,                  // Register write strobe
  input  wire logic [7:0]  i_reg_bit_en,              // Bits touched by the write
  input  wire logic [7:0]  i_reg_wdata,               // Write data
  input  wire logic        i_reg_rd,                  // Register read strobe
  input  wire logic        i_global_irq_enable,       // Enable bit of the status word
  input  wire logic        i_irq_ack,                 // Core takes maskable request
  input  wire logic        i_nmi_ack,                 // Core takes non-maskable request
  output logic [7:0]       o_reg_rdata,               // Read data, one cycle after read
  output logic             o_nmi_req,                 // Non-maskable request pending
  output logic             o_irq_req,                 // Maskable request pending
  output logic [3:0]       o_irq_level,               // Level of presented request
  output logic [15:0]      o_irq_vector,              // Vector of presented request
  output logic             o_standby_release          // Wake a halted core
);

  logic [fpic_pkg::FPIC_NUM_SRC-1:0] src_evt;
  logic [fpic_pkg::FPIC_NUM_SRC-1:0] req_src;
  logic [fpic_pkg::FPIC_NUM_SRC-1:0] mask_src;
  logic [fpic_pkg::FPIC_NUM_SRC-1:0] elig;
  logic [fpic_pkg::FPIC_NUM_SRC-1:0] sw_wr;
  logic [fpic_pkg::FPIC_NUM_SRC-1:0] ack_clr;
  logic [15:0]                       req_img;
  logic [15:0]                       mask_d;
  logic [15:0]                       mask_q;
  logic                              nmi_evt;
  logic                              pick_any;
  logic [3:0]                        pick_idx;
  logic                              ack_take;
  logic                              nmi_d;
  logic                              nmi_q;
  logic                              irq_d;
  logic                              irq_q;
  logic [3:0]                        lvl_d;
  logic [3:0]                        lvl_q;
  logic [15:0]                       vec_d;
  logic [15:0]                       vec_q;
  logic                              stby_d;
  logic                              stby_q;
  logic [7:0]                        rdata_d;
  logic [7:0]                        rdata_q;

  // Source events in priority order; watchdog split by its mode
  always_comb begin
    nmi_evt     = i_wdt_overflow & ~i_wdt_interval_mode;
    src_evt[0]  = i_wdt_overflow & i_wdt_interval_mode;
    src_evt[1]  = i_pin_edge_irq_0;
    src_evt[2]  = i_pin_edge_irq_1;
    src_evt[3]  = i_pin_edge_irq_2;
    src_evt[4]  = i_pin_edge_irq_3;
    src_evt[5]  = i_serial_a_async_rx_done | i_serial_a_sync_rx_done;
    src_evt[6]  = i_serial_b_sync_done;
    src_evt[7]  = i_serial_a_async_tx_done;
    src_evt[8]  = i_interval_tick_irq;
    src_evt[9]  = i_wide_timer_match_irq;
    src_evt[10] = i_byte_timer_match_irq;
    src_evt[11] = i_event_counter_match_irq;
    src_evt[12] = i_watch_tick_irq;
    src_evt[13] = i_key_return_irq;
  end

  // The acknowledge only counts while a maskable request is shown
  assign ack_take = i_irq_ack & irq_q;

  // One request flag per source, fourteen in all
  for (genvar k = 0; k < fpic_pkg::FPIC_NUM_SRC; k++) begin : g_req
    localparam logic [3:0] POS = fpic_pkg::FPIC_SRC_BIT[k];
    // Watchdog flag is write-protected outside interval mode
    assign sw_wr[k] = i_reg_wr && i_reg_bit_en[POS[2:0]]
                      && (i_reg_sel == (POS[3] ? fpic_pkg::FPIC_SEL_REQ_HIGH : fpic_pkg::FPIC_SEL_REQ_LOW))
                      && ((k != 0) || i_wdt_interval_mode);
    assign ack_clr[k] = ack_take && (lvl_q == 4'(k));
    assign mask_src[k] = mask_q[POS];
    fpic_flag_bit #(
      .RESET_VAL (fpic_pkg::FPIC_REQ_RST[0])
    ) u_flag (
      .i_core_clk (i_core_clk),
      .i_rst      (i_rst),
      .i_set      (src_evt[k]),
      .i_wr       (sw_wr[k]),
      .i_wdata    (i_reg_wdata[POS[2:0]]),
      .i_clr      (ack_clr[k]),
      .o_flag     (req_src[k])
    );
  end

  // Request flag image; unused bits stay zero, watchdog bit hidden in watchdog mode
  always_comb begin
    req_img = 16'h0000;
    for (int k = 0; k < fpic_pkg::FPIC_NUM_SRC; k++) begin
      req_img[fpic_pkg::FPIC_SRC_BIT[k]] = req_src[k];
    end
    if (!i_wdt_interval_mode) begin
      req_img[fpic_pkg::FPIC_SRC_BIT[0]] = 1'b0;
    end
  end

  // Mask flags take written bits only; unused bits simply store what is written
  always_comb begin
    mask_d = mask_q;
    if (i_reg_wr && (i_reg_sel == fpic_pkg::FPIC_SEL_MASK_LOW)) begin
      mask_d[7:0] = (mask_q[7:0] & ~i_reg_bit_en) | (i_reg_wdata & i_reg_bit_en);
    end else if (i_reg_wr && (i_reg_sel == fpic_pkg::FPIC_SEL_MASK_HIGH)) begin
      mask_d[15:8] = (mask_q[15:8] & ~i_reg_bit_en) | (i_reg_wdata & i_reg_bit_en);
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      mask_q <= {fpic_pkg::FPIC_MASK_RST, fpic_pkg::FPIC_MASK_RST};
    end else begin
      mask_q <= mask_d;
    end
  end

  // Read mux; watchdog mask bit reads a fixed filler in watchdog mode
  always_comb begin
    rdata_d = rdata_q;
    if (i_reg_rd) begin
      if (i_reg_sel == fpic_pkg::FPIC_SEL_REQ_LOW) begin
        rdata_d = req_img[7:0];
      end else if (i_reg_sel == fpic_pkg::FPIC_SEL_REQ_HIGH) begin
        rdata_d = req_img[15:8];
      end else if (i_reg_sel == fpic_pkg::FPIC_SEL_MASK_LOW) begin
        rdata_d = mask_q[7:0];
        if (!i_wdt_interval_mode) begin
          rdata_d[fpic_pkg::FPIC_SRC_BIT[0][2:0]] = fpic_pkg::FPIC_WDT_MASK_UNDEF;
        end
      end else begin
        rdata_d = mask_q[15:8];
      end
    end
  end

  // Eligible maskable requests need flag, clear mask and global enable
  assign elig = req_src & ~mask_src & {fpic_pkg::FPIC_NUM_SRC{i_global_irq_enable}};

  fpic_prio_pick #(
    .N (fpic_pkg::FPIC_NUM_SRC),
    .W (fpic_pkg::FPIC_IDX_W)
  ) u_pick (
    .i_ready (elig),
    .o_any   (pick_any),
    .o_index (pick_idx)
  );

  // Core hand-off; NMI set beats its acknowledge, NMI hides maskable requests.
  // Maskable requests show two clocks after the event, NMI one; well inside the core's 9-clock minimum.
  always_comb begin
    nmi_d = nmi_q;
    if (nmi_evt) begin
      nmi_d = 1'b1;
    end else if (i_nmi_ack && nmi_q) begin
      nmi_d = 1'b0;
    end
    irq_d  = pick_any & ~nmi_d & ~ack_take;
    lvl_d  = pick_idx;
    vec_d  = nmi_d ? fpic_pkg::FPIC_NMI_VECTOR : fpic_pkg::FPIC_VECTORS[pick_idx];
    stby_d = nmi_d | (|(req_src & ~mask_src));
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      nmi_q   <= 1'b0;
      irq_q   <= 1'b0;
      lvl_q   <= 4'h0;
      vec_q   <= 16'h0000;
      stby_q  <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      nmi_q   <= nmi_d;
      irq_q   <= irq_d;
      lvl_q   <= lvl_d;
      vec_q   <= vec_d;
      stby_q  <= stby_d;
      rdata_q <= rdata_d;
    end
  end

  assign o_nmi_req         = nmi_q;
  assign o_irq_req         = irq_q;
  assign o_irq_level       = lvl_q;
  assign o_irq_vector      = vec_q;
  assign o_standby_release = stby_q;
  assign o_reg_rdata       = rdata_q;

  // Checks on the controller's own flags and outputs
  property p_nmi_raise;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_wdt_overflow && !i_wdt_interval_mode) |=> (o_nmi_req && o_irq_vector == fpic_pkg::FPIC_NMI_VECTOR);
  endproperty
  a_nmi_raise: assert property (p_nmi_raise) else $error("NMI not raised on watchdog overflow");

  property p_nmi_first;
    @(posedge i_core_clk) disable iff (i_rst) o_nmi_req |-> !o_irq_req;
  endproperty
  a_nmi_first: assert property (p_nmi_first) else $error("Maskable request shown beside NMI");

  property p_wdt_maskable;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_wdt_overflow && i_wdt_interval_mode) |=> (req_src[0] && !o_nmi_req[*1]) or (req_src[0] && $past(nmi_q));
  endproperty
  a_wdt_maskable: assert property (p_wdt_maskable) else $error("Interval overflow did not set level 0");

  property p_needs_enable;
    @(posedge i_core_clk) disable iff (i_rst) $rose(o_irq_req) |-> $past(i_global_irq_enable);
  endproperty
  a_needs_enable: assert property (p_needs_enable) else $error("Request shown without global enable");

  property p_all_masked;
    @(posedge i_core_clk) disable iff (i_rst) (&mask_src) |=> !o_irq_req;
  endproperty
  a_all_masked: assert property (p_all_masked) else $error("Masked request presented");

  property p_lowest_wins;
    @(posedge i_core_clk) disable iff (i_rst)
      o_irq_req |-> (($past(elig) & ((14'h0001 << o_irq_level) - 14'h0001)) == 14'h0000);
  endproperty
  a_lowest_wins: assert property (p_lowest_wins) else $error("Lower level pending but not chosen");

  property p_vector_map;
    @(posedge i_core_clk) disable iff (i_rst)
      o_irq_req |-> (o_irq_vector == fpic_pkg::FPIC_VECTORS[o_irq_level]);
  endproperty
  a_vector_map: assert property (p_vector_map) else $error("Vector does not match level");

  property p_ack_clears;
    @(posedge i_core_clk) disable iff (i_rst)
      (ack_take && !src_evt[o_irq_level] && !sw_wr[o_irq_level]) |=> (!req_src[$past(o_irq_level)] && !o_irq_req);
  endproperty
  a_ack_clears: assert property (p_ack_clears) else $error("Acknowledge left flag set");

  property p_sw_set;
    @(posedge i_core_clk) disable iff (i_rst)
      (sw_wr[fpic_pkg::FPIC_LVL_PIN0] && i_reg_wdata[fpic_pkg::FPIC_SRC_BIT[1][2:0]]) |=> req_src[1];
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("Software write did not set flag");

  property p_standby;
    @(posedge i_core_clk) disable iff (i_rst)
      (|(src_evt & ~mask_src) || nmi_evt) |=> ##1 o_standby_release;
  endproperty
  a_standby: assert property (p_standby) else $error("No standby release after request");

  property p_reset_vals;
    @(posedge i_core_clk) disable iff (i_rst)
      $past(i_rst) |-> (mask_q == 16'hFFFF && req_src == 14'h0000 && !o_irq_req);
  endproperty
  a_reset_vals: assert property (p_reset_vals) else $error("Flag reset values wrong");

  property p_wdt_hidden;
    @(posedge i_core_clk) disable iff (i_rst)
      (i_reg_rd && i_reg_sel == fpic_pkg::FPIC_SEL_REQ_LOW && !i_wdt_interval_mode) |=> !o_reg_rdata[0];
  endproperty
  a_wdt_hidden: assert property (p_wdt_hidden) else $error("Watchdog flag visible in watchdog mode");

  c_nmi: cover property (@(posedge i_core_clk) disable iff (i_rst) o_nmi_req && i_nmi_ack);
  c_irq_ack: cover property (@(posedge i_core_clk) disable iff (i_rst) ack_take);
  c_two_pend: cover property (@(posedge i_core_clk) disable iff (i_rst) o_irq_req && ($countones(elig) > 1));
  c_wake: cover property (@(posedge i_core_clk) disable iff (i_rst) $rose(o_standby_release));

endmodule

// [src/fpic_pkg.sv]
// Shared constants for the fixed priority interrupt controller
package fpic_pkg;

  // Source count and index width
  localparam int unsigned FPIC_NUM_SRC = 14;
  localparam int unsigned FPIC_IDX_W   = 4;

  // Register selects on the flag register port
  localparam logic [1:0] FPIC_SEL_REQ_LOW   = 2'h0;
  localparam logic [1:0] FPIC_SEL_REQ_HIGH  = 2'h1;
  localparam logic [1:0] FPIC_SEL_MASK_LOW  = 2'h2;
  localparam logic [1:0] FPIC_SEL_MASK_HIGH = 2'h3;

  // Reset values of the flag registers
  localparam logic [7:0] FPIC_REQ_RST  = 8'h00;
  localparam logic [7:0] FPIC_MASK_RST = 8'hFF;

  // Value returned for the watchdog mask bit while in watchdog mode
  localparam logic FPIC_WDT_MASK_UNDEF = 1'b1;

  // Vector of the non-maskable request
  localparam logic [15:0] FPIC_NMI_VECTOR = 16'h0004;

  // Vector per maskable priority level, level 0 first
  localparam logic [15:0] FPIC_VECTORS [FPIC_NUM_SRC] = '{
    16'h0004, 16'h0006, 16'h0008, 16'h000A, 16'h000C, 16'h000E, 16'h0010,
    16'h0012, 16'h0014, 16'h0016, 16'h0018, 16'h001A, 16'h001E, 16'h0020};

  // Bit position of each level in the {high, low} flag image
  localparam logic [3:0] FPIC_SRC_BIT [FPIC_NUM_SRC] = '{
    4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
    4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hD, 4'hE};

  // Priority levels used by name in the logic
  localparam logic [3:0] FPIC_LVL_WDT  = 4'h0;
  localparam logic [3:0] FPIC_LVL_PIN0 = 4'h1;

  // Core service window, in CPU clocks, and our own presentation delay
  localparam int unsigned FPIC_SERVICE_MIN_CLK = 9;
  localparam int unsigned FPIC_SERVICE_MAX_CLK = 19;
  localparam int unsigned FPIC_PRESENT_CLK     = 2;

endpackage

// [src/fpic_flag_bit.sv]
// One hardware-set, software-written, acknowledge-cleared flag bit
`timescale 1ns/1ps
module fpic_flag_bit #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic i_core_clk, // CPU clock
  input  wire logic i_rst,      // Async reset, active high
  input  wire logic i_set,      // Source event pulse
  input  wire logic i_wr,       // Software write strobe for this bit
  input  wire logic i_wdata,    // Software write value
  input  wire logic i_clr,      // Acknowledge clear pulse
  output logic      o_flag      // Flag state
);

  logic flag_d;
  logic flag_q;

  // Event beats software write and acknowledge so no request is lost
  always_comb begin
    flag_d = flag_q;
    if (i_set) begin
      flag_d = 1'b1;
    end else if (i_wr) begin
      flag_d = i_wdata;
    end else if (i_clr) begin
      flag_d = 1'b0;
    end
  end

  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flag_q <= RESET_VAL;
    end else begin
      flag_q <= flag_d;
    end
  end

  assign o_flag = flag_q;

endmodule

// [src/fpic_prio_pick.sv]
// Fixed priority picker: lowest index wins
`timescale 1ns/1ps
module fpic_prio_pick #(
  parameter int unsigned N = 14,
  parameter int unsigned W = 4
) (
  input  wire logic [N-1:0] i_ready, // Eligible requests
  output logic              o_any,   // At least one eligible
  output logic [W-1:0]      o_index  // Winning index
);

  // Scan from the lowest priority up so level 0 overrides all
  always_comb begin
    o_any   = |i_ready;
    o_index = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (i_ready[i]) begin
        o_index = W'(i);
      end
    end
  end

endmodule

// [verification/fpic_core_model.sv]
// Behavioural CPU core model that takes presented interrupt requests
`timescale 1ns/1ps
module fpic_core_model (
  input  wire logic        i_core_clk,   // CPU clock
  input  wire logic        i_rst,        // Async reset, active high
  input  wire logic        i_nmi_req,    // Non-maskable request shown
  input  wire logic        i_irq_req,    // Maskable request shown
  input  wire logic [3:0]  i_irq_level,  // Presented level
  input  wire logic [15:0] i_irq_vector, // Presented vector
  input  wire logic [3:0]  i_delay,      // Cycles to wait before taking
  output logic             o_irq_ack,    // Take maskable request
  output logic             o_nmi_ack,    // Take non-maskable request
  output int               o_irq_cnt,    // Maskable requests taken
  output int               o_nmi_cnt,    // Non-maskable requests taken
  output logic [3:0]       o_lvl,        // Level last taken
  output logic [15:0]      o_vec         // Vector last taken
);
  int wait_q;
  int hold_q;

  // Drive on the falling edge; a hold-off after each take lets the old request drop first
  always @(negedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_irq_ack <= 1'b0;
      o_nmi_ack <= 1'b0;
      o_irq_cnt <= 0;
      o_nmi_cnt <= 0;
      o_lvl     <= 4'h0;
      o_vec     <= 16'h0000;
      wait_q    <= 0;
      hold_q    <= 0;
    end else begin
      o_irq_ack <= 1'b0;
      o_nmi_ack <= 1'b0;
      if (hold_q > 0) begin
        hold_q <= hold_q - 1;
      end else if (!(i_nmi_req || i_irq_req)) begin
        wait_q <= 0;
      end else if (wait_q < int'(i_delay)) begin
        wait_q <= wait_q + 1;
      end else begin
        wait_q <= 0;
        hold_q <= 3;
        o_vec  <= i_irq_vector;
        if (i_nmi_req) begin // Non-maskable taken first
          o_nmi_ack <= 1'b1;
          o_nmi_cnt <= o_nmi_cnt + 1;
        end else begin
          o_irq_ack <= 1'b1;
          o_lvl     <= i_irq_level;
          o_irq_cnt <= o_irq_cnt + 1;
        end
      end
    end
  end
endmodule

// [verification/fpic_top_tb.sv]
// Self-checking bench for the fixed priority interrupt controller
`timescale 1ns/1ps
module fpic_top_tb;
  logic        clk, rst, imode, rd, wr, ie, irq_ack, nmi_ack, nmi_req, irq_req, sby;
  logic [14:0] src;
  logic [1:0]  sel;
  logic [7:0]  ben, wd, rdata, r;
  logic [3:0]  lvl, m_lvl, dly;
  logic [15:0] vec, m_vec, lf, m16, f16;
  logic [14:0] src_v;
  logic [13:0] plvl, mlvl;
  int          irq_cnt, nmi_cnt, fails, num_checks, cyc, n;

  fpic_top i_fpic_top (.i_core_clk(clk), .i_rst(rst), .i_wdt_overflow(src[0]), .i_wdt_interval_mode(imode),
    .i_pin_edge_irq_0(src[1]), .i_pin_edge_irq_1(src[2]), .i_pin_edge_irq_2(src[3]), .i_pin_edge_irq_3(src[4]),
    .i_serial_a_async_rx_done(src[5]), .i_serial_a_sync_rx_done(src[6]), .i_serial_b_sync_done(src[7]),
    .i_serial_a_async_tx_done(src[8]), .i_interval_tick_irq(src[9]), .i_wide_timer_match_irq(src[10]),
    .i_byte_timer_match_irq(src[11]), .i_event_counter_match_irq(src[12]), .i_watch_tick_irq(src[13]),
    .i_key_return_irq(src[14]), .i_reg_sel(sel), .i_reg_wr(wr), .i_reg_bit_en(ben), .i_reg_wdata(wd),
    .i_reg_rd(rd), .i_global_irq_enable(ie), .i_irq_ack(irq_ack), .i_nmi_ack(nmi_ack), .o_reg_rdata(rdata),
    .o_nmi_req(nmi_req), .o_irq_req(irq_req), .o_irq_level(lvl), .o_irq_vector(vec), .o_standby_release(sby));

  fpic_core_model i_fpic_core_model (.i_core_clk(clk), .i_rst(rst), .i_nmi_req(nmi_req), .i_irq_req(irq_req),
    .i_irq_level(lvl), .i_irq_vector(vec), .i_delay(dly), .o_irq_ack(irq_ack), .o_nmi_ack(nmi_ack),
    .o_irq_cnt(irq_cnt), .o_nmi_cnt(nmi_cnt), .o_lvl(m_lvl), .o_vec(m_vec));

  // Free-running CPU clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Hang guard, far above the thousand or so cycles the run needs
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      end_of_test();
    end
  end

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // Source index to level: the two serial A receive ends share one level
  function automatic logic [3:0] lvl_of(input int k);
    return (k <= 5) ? 4'(k) : 4'(k - 1);
  endfunction

  function automatic logic [15:0] vec_of(input int l);
    return (l < 12) ? 16'(16'h0004 + 2 * l) : ((l == 12) ? 16'h001E : 16'h0020);
  endfunction

  // Per-level bits to the {high, low} flag image; high bits 4 and 7 are unused
  function automatic logic [15:0] img(input logic [13:0] per_lvl);
    logic [15:0] o;
    o = 16'h0000;
    for (int l = 0; l < 14; l++) o[(l < 12) ? l : l + 1] = per_lvl[l];
    return o;
  endfunction

  function automatic logic [13:0] src2lvl(input logic [14:0] p);
    logic [13:0] o;
    o = 14'h0000;
    for (int k = 0; k < 15; k++) if (p[k]) o[lvl_of(k)] = 1'b1;
    return o;
  endfunction

  // Lowest pending level number, the one the rules say is served first
  function automatic int first_lvl(input logic [13:0] v);
    for (int l = 0; l < 14; l++) if (v[l]) return l;
    return 14;
  endfunction

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic reg_wr(input logic [1:0] s, input logic [7:0] en, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    ben = en;
    wd  = d;
    wr  = 1'b1;
    @(negedge clk);
    wr  = 1'b0;
  endtask

  task automatic reg_rd(input logic [1:0] s, output logic [7:0] d);
    @(negedge clk);
    sel = s;
    rd  = 1'b1;
    @(negedge clk);
    rd  = 1'b0;
    d   = rdata;
  endtask

  task automatic pulse(input logic [14:0] p);
    @(negedge clk);
    src = p;
    @(negedge clk);
    src = 15'h0000;
  endtask

  task automatic wait_take(input bit nmi, input int cnt);
    int k;
    k = 0;
    while ((nmi ? nmi_cnt : irq_cnt) < cnt && k < 200) begin
      @(negedge clk);
      k++;
    end
    check("request taken", 16'(k < 200), 16'h0001);
  endtask

  task automatic read_flags(output logic [15:0] f);
    reg_rd(fpic_pkg::FPIC_SEL_REQ_LOW, f[7:0]);
    reg_rd(fpic_pkg::FPIC_SEL_REQ_HIGH, f[15:8]);
  endtask

  task automatic end_of_test();
    $display("Checks made %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {rst, imode, rd, wr, ie, src, sel, ben, wd} = '0;
    rst = 1'b1;
    imode = 1'b1;
    dly = 4'h1;
    lf = 16'h001D;
    n = 0;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    read_flags(f16);
    check("request flags after reset", f16, 16'h0000);
    reg_rd(fpic_pkg::FPIC_SEL_MASK_LOW, r);
    check("mask low after reset", r, 8'hFF);
    reg_rd(fpic_pkg::FPIC_SEL_MASK_HIGH, r);
    check("mask high after reset", r, 8'hFF);
    check("standby after reset", sby, 16'h0000);
    $display("test reset done");
    // Every source alone, unmasked, then served and its flag cleared
    reg_wr(fpic_pkg::FPIC_SEL_MASK_LOW, 8'hFF, 8'h00);
    reg_wr(fpic_pkg::FPIC_SEL_MASK_HIGH, 8'hFF, 8'h90); // Unused mask bits kept at one
    ie = 1'b1;
    for (int k = 0; k < 15; k++) begin
      pulse(15'h0001 << k);
      check("request before two clocks", irq_req, 16'h0000);
      @(negedge clk);
      check("request shown", irq_req, 16'h0001);
      check("vector shown", vec, vec_of(lvl_of(k)));
      n++;
      wait_take(1'b0, n);
      check("served level", m_lvl, lvl_of(k));
      check("served vector", m_vec, vec_of(lvl_of(k)));
      read_flags(f16);
      check("flags after service", f16, 16'h0000);
    end
    reg_wr(fpic_pkg::FPIC_SEL_REQ_HIGH, 8'h40, 8'h40); // Unused request bits left at zero
    n++;
    wait_take(1'b0, n);
    check("software set level", m_lvl, 16'h000D);
    reg_wr(fpic_pkg::FPIC_SEL_REQ_LOW, 8'h02, 8'h02);
    n++;
    wait_take(1'b0, n);
    check("software set pin level", m_lvl, 16'h0001);
    $display("test single sources done");
    // Random bursts against random masks, held back first by the enable
    for (int i = 0; i < 20; i++) begin
      lf = lfsr(lf);
      src_v = lf[14:0];
      lf = lfsr(lf);
      mlvl = lf[13:0];
      m16 = img(mlvl) | 16'h9000;
      dly = lf[15:13] + 4'h1;
      plvl = src2lvl(src_v) & ~mlvl;
      ie = 1'b0;
      reg_wr(fpic_pkg::FPIC_SEL_MASK_LOW, 8'hFF, m16[7:0]);
      reg_wr(fpic_pkg::FPIC_SEL_MASK_HIGH, 8'hFF, m16[15:8]);
      pulse(src_v);
      read_flags(f16);
      check("flags after burst", f16, img(src2lvl(src_v)));
      check("standby with enable off", sby, 16'(plvl != 0));
      check("request held by enable", irq_req, 16'h0000);
      ie = 1'b1;
      // Each unmasked level must be served in ascending level order
      while (plvl != 0) begin
        n++;
        wait_take(1'b0, n);
        check("burst order", m_lvl, 16'(first_lvl(plvl)));
        plvl[first_lvl(plvl)] = 1'b0;
      end
      read_flags(f16);
      check("masked flags kept", f16, img(src2lvl(src_v) & mlvl));
      reg_wr(fpic_pkg::FPIC_SEL_REQ_LOW, 8'hFF, 8'h00);
      reg_wr(fpic_pkg::FPIC_SEL_REQ_HIGH, 8'hFF, 8'h00); // Unused bits written as zero
    end
    $display("test random bursts done");
    // Watchdog form switched only while no watchdog request is pending
    imode = 1'b0;
    ie = 1'b0;
    reg_wr(fpic_pkg::FPIC_SEL_MASK_LOW, 8'hFF, 8'h00);
    reg_rd(fpic_pkg::FPIC_SEL_MASK_LOW, r);
    check("watchdog mask read filler", r, 8'h01);
    pulse(15'h0001);
    check("nmi shown without enable", nmi_req, 16'h0001);
    check("nmi vector shown", vec, 16'h0004);
    wait_take(1'b1, 1);
    check("nmi vector taken", m_vec, 16'h0004);
    // NMI and a pin edge together: the NMI must go first
    ie = 1'b1;
    pulse(15'h0003);
    @(negedge clk);
    check("nmi beside pin", nmi_req, 16'h0001);
    check("maskable held behind nmi", irq_req, 16'h0000);
    wait_take(1'b1, 2);
    check("nmi taken first", m_vec, 16'h0004);
    n++;
    wait_take(1'b0, n);
    check("pin served after nmi", m_lvl, 16'h0001);
    read_flags(f16);
    check("watchdog flag hidden", f16, 16'h0000);
    $display("test non-maskable done");
    end_of_test();
  end
endmodule
